/* File: hw/scl_timing.sv */
// I2C master SCL timing core with the interface's register file.
// Assumes a classic Wishbone master on clk_i and an open-drain SCL pin
// resolved outside; packet check value comes from the byte engine.
`timescale 1ns/1ps

module scl_timing
    import scl_timing_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire wb_req_type wb_req_i,
    output wb_rsp_type      wb_rsp_o,
    input  wire logic       master_run_i,
    input  wire logic [7:0] packet_check_value_i,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    output logic            interface_on_o,
    output logic [5:0]      input_clock_setting_o
);

    // ******************************************************************
    // Register file
    // ******************************************************************
    logic [7:0] regs [REG_COUNT];
    logic       ack;
    logic [7:0] read_byte;
    logic       access;
    logic       write_hit;
    logic [3:0] index;

    function automatic logic [7:0] write_mask(input logic [3:0] idx);
        case (idx)
            IDX_INPUT_CLOCK:        write_mask = MASK_INPUT_CLOCK;
            IDX_OWN_ADDRESS_HIGH:   write_mask = MASK_OWN_HIGH;
            IDX_INT_DMA_CONTROL:    write_mask = MASK_INT_DMA;
            IDX_CLOCK_DIVIDER_HIGH: write_mask = MASK_DIVIDER_HIGH;
            IDX_RISE_TIME_LIMIT:    write_mask = MASK_RISE_TIME;
            IDX_STATUS_ONE,
            IDX_STATUS_TWO,
            IDX_STATUS_THREE,
            IDX_PACKET_CHECK:       write_mask = RESET_ZERO;
            default:                write_mask = 8'hFF;
        endcase
    endfunction

    // Indices from REG_COUNT up have no register behind them
    function automatic logic is_mapped(input logic [3:0] idx);
        is_mapped = (int'(idx) < REG_COUNT);
    endfunction

    assign index     = wb_req_i.adr[5:2];
    assign access    = wb_req_i.cyc && wb_req_i.stb && !ack;
    // A write lands at the edge where the master samples ack; the
    // request still stands there, so no copy of it is kept
    assign write_hit = wb_req_i.cyc && wb_req_i.stb && ack && wb_req_i.we
                       && wb_req_i.sel[0] && is_mapped(index);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                regs[i] <= RESET_ZERO;
            regs[IDX_RISE_TIME_LIMIT] <= RESET_RISE_TIME;
        end
        else if (write_hit)
        begin
            // Divider and rise time are held by software only while the
            // interface is off; writes are still accepted here.
            regs[index] <= wb_req_i.dat[7:0] & write_mask(index);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= access;
    end

    always_comb
    begin
        read_byte = RESET_ZERO;
        if (is_mapped(index))
            read_byte = regs[index];
        if (index == IDX_PACKET_CHECK)
            read_byte = regs[IDX_CONTROL_ONE][POS_CRC_CHECK_ENABLE]
                        ? packet_check_value_i : RESET_ZERO;
    end

    logic [7:0] read_data;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            read_data <= RESET_ZERO;
        else if (access)
            read_data <= read_byte;
    end

    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = {24'h000000, read_data};

    // ******************************************************************
    // SCL timing
    // ******************************************************************
    typedef enum logic [2:0] {
        IDLE_ST = 3'b001,
        LOW_ST  = 3'b010,
        HIGH_ST = 3'b100
    } phase_type;

    phase_type   phase;
    phase_type   next_phase;
    logic [11:0] divider;
    logic [11:0] unit_count;
    logic [11:0] next_unit_count;
    logic [4:0]  units_high;
    logic [4:0]  units_low;
    logic [4:0]  units_now;
    logic [4:0]  unit_total;
    logic [4:0]  next_unit_total;
    logic [5:0]  rise_limit;
    logic [5:0]  rise_count;
    logic [5:0]  next_rise_count;
    logic        fast;
    logic        ratio;
    logic        on;
    logic        running;
    logic        rise_wait;
    logic        counting;
    logic        unit_done;
    logic        phase_done;

    // Last cycle of one divider unit. A zero divider acts as one, so the
    // counter never has to wrap through its full range.
    function automatic logic last_cycle(input logic [11:0] count,
                                        input logic [11:0] limit);
        last_cycle = (count + 12'h001 >= limit);
    endfunction

    // Last divider unit of a phase that is length units long
    function automatic logic last_unit(input logic [4:0] total,
                                       input logic [4:0] length);
        last_unit = (total + 5'h01 >= length);
    endfunction

    assign on      = regs[IDX_CONTROL_ONE][POS_INTERFACE_ON];
    assign fast    = regs[IDX_CLOCK_DIVIDER_HIGH][POS_FAST_SPEED];
    assign ratio   = regs[IDX_CLOCK_DIVIDER_HIGH][POS_RATIO_SELECT];
    assign divider = {regs[IDX_CLOCK_DIVIDER_HIGH][3:0],
                      regs[IDX_CLOCK_DIVIDER_LOW]};
    assign running = on && master_run_i;

    // Phase lengths in divider units for the selected speed
    always_comb
    begin
        if (!fast)
        begin
            units_high = UNITS_STD_HIGH;
            units_low  = UNITS_STD_LOW;
        end
        else if (!ratio)
        begin
            units_high = UNITS_FAST_HIGH;
            units_low  = UNITS_FAST_LOW;
        end
        else
        begin
            units_high = UNITS_DUTY_HIGH;
            units_low  = UNITS_DUTY_LOW;
        end
    end

    // ******************************************************************
    // Phase sequencing
    // ******************************************************************
    assign rise_limit = regs[IDX_RISE_TIME_LIMIT][5:0];

    // While released SCL has not come up, the high phase is held, for
    // at most the rise allowance, so a slow edge does not eat into it.
    // A device stretching SCL longer than that is not waited for.
    assign rise_wait  = (phase == HIGH_ST) && !scl_i
                        && (rise_count < rise_limit);
    assign counting   = ((phase == LOW_ST) || (phase == HIGH_ST))
                        && !rise_wait;
    assign units_now  = (phase == HIGH_ST) ? units_high : units_low;
    assign unit_done  = counting && last_cycle(unit_count, divider);
    assign phase_done = unit_done && last_unit(unit_total, units_now);

    always_comb
    begin
        next_phase = phase;
        case (phase)
            IDLE_ST:
                next_phase = LOW_ST;
            LOW_ST:
                if (phase_done)
                    next_phase = HIGH_ST;
            HIGH_ST:
                if (phase_done)
                    next_phase = LOW_ST;
            default:
                next_phase = IDLE_ST;
        endcase
    end

    always_comb
    begin
        next_unit_count = unit_count;
        if (unit_done)
            next_unit_count = 12'h000;
        else if (counting)
            next_unit_count = unit_count + 12'h001;
    end

    always_comb
    begin
        next_unit_total = unit_total;
        if (phase_done)
            next_unit_total = 5'h00;
        else if (unit_done)
            next_unit_total = unit_total + 5'h01;
    end

    // Cleared outside the high phase, so each rise is timed afresh
    always_comb
    begin
        next_rise_count = rise_count;
        if (phase != HIGH_ST)
            next_rise_count = 6'h00;
        else if (rise_wait)
            next_rise_count = rise_count + 6'h01;
    end

    // ******************************************************************
    // Phase registers
    // ******************************************************************
    // Dropping the enable or the run request abandons the current
    // phase at once and releases SCL.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !running)
            phase <= IDLE_ST;
        else
            phase <= next_phase;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !running)
            unit_count <= 12'h000;
        else
            unit_count <= next_unit_count;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !running)
            unit_total <= 5'h00;
        else
            unit_total <= next_unit_total;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !running)
            rise_count <= 6'h00;
        else
            rise_count <= next_rise_count;
    end

    // ******************************************************************
    // Pin and configuration outputs
    // ******************************************************************
    // Open drain: SCL is only ever pulled low. The high level comes from
    // the pull-up, which is why the high phase watches the line.
    assign scl_o    = 1'b0;
    assign scl_oe_o = (phase == LOW_ST);

    assign interface_on_o        = on;
    assign input_clock_setting_o = regs[IDX_INPUT_CLOCK][5:0];

endmodule // scl_timing

/* File: hw/scl_timing_pkg.sv */
// Package for the I2C master SCL timing block: register map, fields,
// reset values and bus carriers. Assumes a classic Wishbone slave port.
package scl_timing_pkg;

    // ******************************************************************
    // Register indices (byte address is four times the index)
    // ******************************************************************
    localparam logic [3:0] IDX_CONTROL_ONE        = 4'h0;
    localparam logic [3:0] IDX_CONTROL_TWO        = 4'h1;
    localparam logic [3:0] IDX_INPUT_CLOCK        = 4'h2;
    localparam logic [3:0] IDX_OWN_ADDRESS_LOW    = 4'h3;
    localparam logic [3:0] IDX_OWN_ADDRESS_HIGH   = 4'h4;
    localparam logic [3:0] IDX_SECOND_OWN_ADDRESS = 4'h5;
    localparam logic [3:0] IDX_DATA_BYTE          = 4'h6;
    localparam logic [3:0] IDX_STATUS_ONE         = 4'h7;
    localparam logic [3:0] IDX_STATUS_TWO         = 4'h8;
    localparam logic [3:0] IDX_STATUS_THREE       = 4'h9;
    localparam logic [3:0] IDX_INT_DMA_CONTROL    = 4'hA;
    localparam logic [3:0] IDX_CLOCK_DIVIDER_LOW  = 4'hB;
    localparam logic [3:0] IDX_CLOCK_DIVIDER_HIGH = 4'hC;
    localparam logic [3:0] IDX_RISE_TIME_LIMIT    = 4'hD;
    localparam logic [3:0] IDX_PACKET_CHECK       = 4'hE;
    localparam int         REG_COUNT              = 15;

    // ******************************************************************
    // Field positions and reset values
    // ******************************************************************
    localparam int         POS_INTERFACE_ON     = 0;
    localparam int         POS_CRC_CHECK_ENABLE = 5;
    localparam int         POS_FAST_SPEED       = 7;
    localparam int         POS_RATIO_SELECT     = 6;
    localparam logic [7:0] MASK_DIVIDER_HIGH    = 8'hCF;
    localparam logic [7:0] MASK_RISE_TIME       = 8'h3F;
    localparam logic [7:0] MASK_INPUT_CLOCK     = 8'h3F;
    localparam logic [7:0] MASK_INT_DMA         = 8'h1F;
    localparam logic [7:0] MASK_OWN_HIGH        = 8'hC6;
    localparam logic [7:0] RESET_ZERO           = 8'h00;
    localparam logic [7:0] RESET_RISE_TIME      = 8'h02;

    // Phase lengths in divider units
    localparam logic [4:0] UNITS_STD_HIGH  = 5'h01;
    localparam logic [4:0] UNITS_STD_LOW   = 5'h01;
    localparam logic [4:0] UNITS_FAST_HIGH = 5'h01;
    localparam logic [4:0] UNITS_FAST_LOW  = 5'h02;
    localparam logic [4:0] UNITS_DUTY_HIGH = 5'h09;
    localparam logic [4:0] UNITS_DUTY_LOW  = 5'h10;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [5:0]  adr;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_type;

endpackage

/* File: dv/scl_bus_model.sv */
// SCL wire as seen by the far-side bus devices: pull-up with slow rise.
// Assumes the block pulls SCL low while scl_oe_i is high.
`timescale 1ns/1ps
module scl_bus_model #(
    parameter int RISE = 4
) (
    input  wire logic clk_i,
    input  wire logic scl_oe_i,
    output logic      scl_line_o
);
    // Line starts released and already pulled up
    int cnt = RISE;
    // Pull-up needs RISE cycles to lift the line after release
    always_ff @(posedge clk_i)
    begin
        if (scl_oe_i)
            cnt <= 0;
        else if (cnt < RISE)
            cnt <= cnt + 1;
    end
    assign scl_line_o = !scl_oe_i && (cnt >= RISE);
endmodule // scl_bus_model

/* File: dv/scl_timing_properties.sv */
// Port checks for the SCL timing block, bound to its top module.
// Assumes one clock clk_i and synchronous active-high rst_i.
`timescale 1ns/1ps
module scl_timing_properties
    import scl_timing_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire wb_req_type wb_req_i,
    input wire wb_rsp_type wb_rsp_o,
    input wire logic       master_run_i,
    input wire logic [7:0] packet_check_value_i,
    input wire logic       scl_i,
    input wire logic       scl_o,
    input wire logic       scl_oe_o,
    input wire logic       interface_on_o,
    input wire logic [5:0] input_clock_setting_o
);
    // ****
    // Assertions
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_ok;
    assign wr_ok = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
        && wb_req_i.sel[0] && wb_rsp_o.ack;
    a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb
        && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("request not answered next cycle");
    a_dat_upper_zero: assert property (wb_rsp_o.ack
        |-> wb_rsp_o.dat[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_scl_open_drain: assert property (scl_o == 1'b0)
        else $error("scl driven high");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i
        |=> !wb_rsp_o.ack && !scl_oe_o)
        else $error("outputs active after reset");
    a_run_idle: assert property ((!master_run_i)[*3] |-> !scl_oe_o)
        else $error("scl pulled without run");
    a_clock_mirror: assert property (wr_ok
        && wb_req_i.adr == {IDX_INPUT_CLOCK, 2'b00}
        |=> input_clock_setting_o == $past(wb_req_i.dat[5:0]))
        else $error("input clock setting not updated");
    a_on_mirror: assert property (wr_ok
        && wb_req_i.adr == {IDX_CONTROL_ONE, 2'b00}
        |=> interface_on_o == $past(wb_req_i.dat[0]))
        else $error("interface on not updated");
    c_write: cover property (wr_ok);
    c_scl_low: cover property ($rose(scl_oe_o));
    c_slow_rise: cover property (!scl_oe_o && !scl_i);
endmodule // scl_timing_properties

bind scl_timing scl_timing_properties chk_u (.clk_i, .rst_i, .wb_req_i,
    .wb_rsp_o, .master_run_i, .packet_check_value_i, .scl_i, .scl_o,
    .scl_oe_o, .interface_on_o, .input_clock_setting_o);

/* File: dv/scl_timing_tb.sv */
// Self-checking bench: Wishbone register access and SCL phase lengths.
// Assumes the bus model lifts SCL RISE cycles after each release.
`timescale 1ns/1ps
module scl_timing_tb;
    import scl_timing_pkg::*;
    localparam int RISE = 4;
    logic       clk_i, rst_i, run, scl, oe, on;
    logic [7:0] pcv, q, hb;
    logic [5:0] ics;
    logic [4:0] ul, uh;
    wb_req_type req;
    wb_rsp_type rsp;
    int         mismatches, num_checks, lo, hi, div;
    scl_timing dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_rsp_o(rsp), .master_run_i(run), .packet_check_value_i(pcv),
        .scl_i(scl), .scl_o(), .scl_oe_o(oe), .interface_on_o(on),
        .input_clock_setting_o(ics));
    scl_bus_model #(.RISE(RISE)) bus_u (.clk_i(clk_i), .scl_oe_i(oe),
        .scl_line_o(scl));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task close_out;
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_rng(input int got, input int lo_b, input int hi_b);
        num_checks++;
        if (got < lo_b || got > hi_b)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo_b);
        end
    endtask
    // Holds the request until ack is sampled, then releases it
    task wb(input logic [3:0] idx, input logic we, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, 4'hF, {idx, 2'b00}, {24'h000000, d}};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        q = rsp.dat[7:0];
        req <= '0;
    endtask
    task rd(input logic [3:0] idx, input logic [7:0] exp);
        wb(idx, 1'b0, 8'h00);
        chk(q, exp);
    endtask
    initial
    begin
        repeat (50000) @(posedge clk_i);
        mismatches++;
        close_out;
    end
    initial
    begin
        req = '0; run = 1'b0; pcv = 8'hA5; rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i++)
            rd(i[3:0], (i == 13) ? 8'h02 : 8'h00);
        wb(IDX_CLOCK_DIVIDER_HIGH, 1'b1, 8'hFF);
        rd(IDX_CLOCK_DIVIDER_HIGH, 8'hCF);
        wb(IDX_RISE_TIME_LIMIT, 1'b1, 8'hFF);
        rd(IDX_RISE_TIME_LIMIT, 8'h3F);
        wb(IDX_INPUT_CLOCK, 1'b1, 8'hC8);
        @(posedge clk_i);
        chk({2'b00, ics}, 8'h08);
        wb(IDX_CONTROL_ONE, 1'b1, 8'h20);
        rd(IDX_PACKET_CHECK, 8'hA5);
        wb(IDX_PACKET_CHECK, 1'b1, 8'h3C);
        rd(IDX_PACKET_CHECK, 8'hA5);
        wb(IDX_CONTROL_ONE, 1'b1, 8'h00);
        rd(IDX_PACKET_CHECK, 8'h00);
        // Standard with a 12-bit divider, fast, fast with ratio select
        for (int m = 0; m < 3; m++)
        begin
            div = (m == 0) ? 261 : 5;
            hb = {m != 0, m == 2, 2'b00, (m == 0) ? 4'h1 : 4'h0};
            ul = (m == 0) ? UNITS_STD_LOW : (m == 1) ? UNITS_FAST_LOW
                : UNITS_DUTY_LOW;
            uh = (m == 0) ? UNITS_STD_HIGH : (m == 1) ? UNITS_FAST_HIGH
                : UNITS_DUTY_HIGH;
            wb(IDX_CONTROL_ONE, 1'b1, 8'h00);
            wb(IDX_INPUT_CLOCK, 1'b1, (m == 0) ? 8'h08 : 8'h14);
            wb(IDX_CLOCK_DIVIDER_LOW, 1'b1, 8'h05);
            wb(IDX_CLOCK_DIVIDER_HIGH, 1'b1, hb);
            // No filter delay is added to the rise allowance
            wb(IDX_RISE_TIME_LIMIT, 1'b1, 8'(RISE + 1));
            wb(IDX_CONTROL_ONE, 1'b1, 8'h01);
            @(posedge clk_i);
            chk({7'h00, on}, 8'h01);
            run <= 1'b1;
            // Outputs are sampled mid-cycle, away from the edge that
            // launches them; each sample stands for one clock cycle
            do @(negedge clk_i); while (oe !== 1'b1);
            lo = 0;
            while (oe === 1'b1)
            begin
                lo++;
                @(negedge clk_i);
            end
            hi = 0;
            while (oe !== 1'b1)
            begin
                hi++;
                @(negedge clk_i);
            end
            @(posedge clk_i);
            run <= 1'b0;
            chk_rng(lo, ul * div, ul * div);
            chk_rng(hi, uh * div + RISE, uh * div + RISE);
        end
        // Reset in mid-run returns registers and SCL to their idle state
        wb(IDX_CONTROL_ONE, 1'b1, 8'h01);
        run <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        run <= 1'b0;
        chk({7'h00, oe}, 8'h00);
        rd(IDX_RISE_TIME_LIMIT, RESET_RISE_TIME);
        rd(IDX_CLOCK_DIVIDER_HIGH, RESET_ZERO);
        rd(IDX_CONTROL_ONE, RESET_ZERO);
        close_out;
    end
endmodule // scl_timing_tb
